// File: qsf_flash.sv
// serial flash device front end with array, one-time area and busy engine
`timescale 1ns/1ps
module qsf_flash #(
  parameter int unsigned AW       = qsf_pkg::ARRAY_AW,
  parameter int unsigned BUSY_CYC = qsf_pkg::BUSY_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire qsf_pkg::qsf_pins_in_t  pin_i,
  output      qsf_pkg::qsf_pins_out_t pin_o,
  output      logic                   write_in_progress_flag
);
  import qsf_pkg::*;

  if (AW < BLOCK_AW || AW > ADDR_BITS)
    $error("qsf_flash: AW out of range");
  if (BUSY_CYC < 1 || BUSY_CYC > 65535)
    $error("qsf_flash: BUSY_CYC out of range");

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 cs;
    logic                 sclk;
    qsf_state_t           st;
    qsf_op_t              op;
    logic [7:0]           opc;
    logic [3:0]           cnt;
    logic [7:0]           sh;
    logic [4:0]           acnt;
    logic [ADDR_BITS-1:0] addr;
    logic [7:0]           dcnt;
    logic [7:0]           dcfg;
    logic [7:0]           osh;
    logic                 wel;
    logic                 lock;
    logic                 prog_any;
    logic [15:0]          bcnt;
    logic [AW-1:0]        er_addr;
    logic [AW:0]          er_left;
    logic                 busy;
    qsf_pins_out_t        po;
  } qsf_core_t;

  qsf_core_t q;
  qsf_core_t d;
  logic [7:0]        mem [0:(1<<AW)-1];
  logic [7:0]        otp [0:(1<<OTP_AW)-1];
  logic [7:0]        mem_rd_q;
  logic [7:0]        otp_rd_q;
  logic              mem_we;
  logic              mem_prog;
  logic [AW-1:0]     mem_wa;
  logic [7:0]        mem_wd;
  logic              otp_we;
  logic [OTP_AW-1:0] otp_wa;
  logic [7:0]        otp_wd;
  logic              rise;
  logic              fall;
  logic [7:0]        nbyte;
  logic [7:0]        ob;
  logic [3:0]        ncnt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [ADDR_BITS-1:0] shift_in(input logic [ADDR_BITS-1:0] v,
                                                    input logic [2:0] n,
                                                    input logic [3:0] dq);
    logic [ADDR_BITS-1:0] r;
    r = {v[ADDR_BITS-2:0], dq[0]};
    if (n == LANES_2)
      r = {v[ADDR_BITS-3:0], dq[1:0]};
    else if (n == LANES_4)
      r = {v[ADDR_BITS-5:0], dq[3:0]};
    return r;
  endfunction

  function automatic qsf_op_t decode(input logic [7:0] c);
    qsf_op_t o;
    o = '{kind: K_NONE, has_addr: 1'b0, alanes: LANES_1, dlanes: LANES_1, dmy: DMY_NONE};
    case (c)
      OP_WRITE_EN: o.kind = K_WRITE_EN;
      OP_WRDI:   o.kind = K_WRDI;
      OP_RDSR:   o.kind = K_RDSR;
      OP_SETDMY: o.kind = K_SETDMY;
      OP_OTPLK:  o.kind = K_OTPLK;
      OP_CE:     o.kind = K_ERASE;
      OP_READ:   o = '{K_READ, 1'b1, LANES_1, LANES_1, DMY_NONE};
      OP_FAST:   o = '{K_READ, 1'b1, LANES_1, LANES_1, DMY_1L};
      OP_DOUT:   o = '{K_READ, 1'b1, LANES_1, LANES_2, DMY_1L};
      OP_DIO:    o = '{K_READ, 1'b1, LANES_2, LANES_2, DMY_2L};
      OP_QIO:    o = '{K_READ, 1'b1, LANES_4, LANES_4, DMY_CFG};
      OP_PP:     o = '{K_PROG, 1'b1, LANES_1, LANES_1, DMY_NONE};
      OP_QPP:    o = '{K_PROG, 1'b1, LANES_1, LANES_4, DMY_NONE};
      OP_SE, OP_HBE, OP_BE:
                 o = '{K_ERASE, 1'b1, LANES_1, LANES_1, DMY_NONE};
      OP_OTPRD:  o = '{K_OTPRD, 1'b1, LANES_1, LANES_1, DMY_1L};
      OP_OTPPR:  o = '{K_OTPPR, 1'b1, LANES_1, LANES_1, DMY_NONE};
      default:   o.kind = K_NONE;
    endcase
    return o;
  endfunction

  function automatic logic [3:0] lane_oe(input logic [2:0] n);
    logic [3:0] r;
    r = 4'h2;
    if (n == LANES_2)
      r = 4'h3;
    else if (n == LANES_4)
      r = 4'hF;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d        = q;
    mem_we   = 1'b0;
    mem_prog = 1'b0;
    mem_wa   = '0;
    mem_wd   = 8'hFF;
    otp_we   = 1'b0;
    otp_wa   = '0;
    otp_wd   = 8'hFF;
    nbyte    = 8'h00;
    ob       = 8'h00;
    ncnt     = 4'h0;

    d.cs   = pin_i.csb;
    d.sclk = pin_i.sclk;
    // edges counted whichever the idle level is
    rise   = pin_i.sclk & ~q.sclk & ~pin_i.csb;
    fall   = ~pin_i.sclk & q.sclk & ~pin_i.csb;

    // busy engine: erase fills with ones, then the busy timer runs out
    if (q.er_left != '0)
    begin
      mem_we    = 1'b1;
      mem_wa    = q.er_addr;
      mem_wd    = 8'hFF;
      d.er_addr = q.er_addr + 1'b1;
      d.er_left = q.er_left - 1'b1;
    end
    else if (q.bcnt != '0)
      d.bcnt = q.bcnt - 1'b1;

    if (pin_i.csb)
    begin
      d.st    = S_IDLE;
      d.po.oe = 4'h0;
      if (!q.cs)
      begin
        // instruction completes on the select rising edge
        if (q.st == S_WAIT && q.op.kind == K_WRITE_EN)
          d.wel = 1'b1;
        else if (q.st == S_WAIT && q.op.kind == K_WRDI)
          d.wel = 1'b0;
        else if (q.st == S_WAIT && q.op.kind == K_ERASE && q.wel)
        begin
          d.wel  = 1'b0;
          d.bcnt = 16'(BUSY_CYC);
          if (q.opc == OP_CE)
            d.er_left = (AW+1)'(1) << AW;
          else if (q.opc == OP_SE)
            d.er_left = (AW+1)'(1) << SECTOR_AW;
          else if (q.opc == OP_HBE)
            d.er_left = (AW+1)'(1) << HALF_AW;
          else
            d.er_left = (AW+1)'(1) << BLOCK_AW;
          d.er_addr = q.addr[AW-1:0] & ~(d.er_left[AW-1:0] - 1'b1);
        end
        else if ((q.op.kind == K_PROG || q.op.kind == K_OTPPR) && q.prog_any)
        begin
          d.wel  = 1'b0;
          d.bcnt = 16'(BUSY_CYC);
        end
        else if (q.st == S_WAIT && q.op.kind == K_OTPLK && q.wel)
        begin
          d.lock = 1'b1;
          d.wel  = 1'b0;
          d.bcnt = 16'(BUSY_CYC);
        end
        d.prog_any = 1'b0;
      end
    end
    else if (q.cs)
    begin
      // only a seen high-to-low edge opens an instruction
      d.st       = S_CMD;
      d.cnt      = 4'h0;
      d.acnt     = 5'h0;
      d.prog_any = 1'b0;
    end
    else
    begin
      case (q.st)
        S_CMD:
        begin
          if (rise)
          begin
            nbyte = 8'(shift_in({16'h0000, q.sh}, LANES_1, pin_i.dq));
            d.sh  = nbyte;
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == 4'h7)
            begin
              d.opc  = nbyte;
              d.op   = decode(nbyte);
              d.cnt  = 4'h0;
              d.addr = '0;
              if (q.busy && d.op.kind != K_RDSR)
                d.st = S_IGNORE;
              else if (d.op.has_addr)
                d.st = S_ADDR;
              else if (d.op.kind == K_RDSR)
                d.st = S_DOUT;
              else if (d.op.kind == K_SETDMY)
                d.st = S_DIN;
              else
                d.st = S_WAIT;
            end
          end
        end
        S_ADDR:
        begin
          if (rise)
          begin
            d.addr = shift_in(q.addr, q.op.alanes, pin_i.dq);
            d.acnt = q.acnt + 5'(q.op.alanes);
            if (q.acnt + 5'(q.op.alanes) == 5'(ADDR_BITS))
            begin
              if (q.op.dmy == DMY_1L)
                d.dcnt = DMY_BYTE_1L;
              else if (q.op.dmy == DMY_2L)
                d.dcnt = DMY_BYTE_2L;
              else
                d.dcnt = q.dcfg;
              if (q.op.dmy != DMY_NONE)
                d.st = S_DUMMY;
              else if (q.op.kind == K_READ || q.op.kind == K_OTPRD)
                d.st = S_DOUT;
              else if (q.op.kind == K_PROG || q.op.kind == K_OTPPR)
                d.st = S_DIN;
              else
                d.st = S_WAIT;
            end
          end
        end
        S_DUMMY:
        begin
          if (q.dcnt == 8'h00 || (rise && q.dcnt == 8'h01))
            d.st = S_DOUT;
          else if (rise)
            d.dcnt = q.dcnt - 1'b1;
        end
        S_DOUT:
        begin
          if (fall)
          begin
            // load a fresh byte once the previous one is spent
            if (q.cnt != 4'h0)
              ob = q.osh;
            else if (q.op.kind == K_RDSR)
            begin
              ob              = 8'h00;
              ob[ST_BUSY_BIT] = q.busy;
              ob[ST_WEL_BIT]  = q.wel;
              ob[ST_LOCK_BIT] = q.lock;
            end
            else if (q.op.kind == K_OTPRD)
              ob = otp_rd_q;
            else
              ob = mem_rd_q;
            d.po.oe = lane_oe(q.op.dlanes);
            if (q.op.dlanes == LANES_4)
              d.po.dq = ob[7:4];
            else if (q.op.dlanes == LANES_2)
              d.po.dq = {2'b00, ob[7:6]};
            else
              d.po.dq = {2'b00, ob[7], 1'b0};
            d.osh = ob << q.op.dlanes;
            ncnt  = ((q.cnt == 4'h0) ? 4'h8 : q.cnt) - 4'(q.op.dlanes);
            d.cnt = ncnt;
            if (ncnt == 4'h0 && q.op.kind != K_RDSR)
              d.addr = q.addr + 1'b1;
          end
        end
        S_DIN:
        begin
          if (rise)
          begin
            nbyte = 8'(shift_in({16'h0000, q.sh}, q.op.dlanes, pin_i.dq));
            d.sh  = nbyte;
            d.cnt = q.cnt + 4'(q.op.dlanes);
            if (q.cnt + 4'(q.op.dlanes) == 4'h8)
            begin
              d.cnt = 4'h0;
              if (q.op.kind == K_SETDMY)
              begin
                d.dcfg = nbyte;
                d.st   = S_WAIT;
              end
              else if (q.op.kind == K_PROG && q.wel && q.er_left == '0)
              begin
                mem_we     = 1'b1;
                mem_prog   = 1'b1;
                mem_wa     = q.addr[AW-1:0];
                mem_wd     = nbyte;
                d.prog_any = 1'b1;
                d.addr     = {q.addr[ADDR_BITS-1:PAGE_AW], q.addr[PAGE_AW-1:0] + 8'h01};
              end
              else if (q.op.kind == K_OTPPR && q.wel && !q.lock)
              begin
                otp_we     = 1'b1;
                otp_wa     = q.addr[OTP_AW-1:0];
                otp_wd     = nbyte;
                d.prog_any = 1'b1;
                d.addr     = q.addr + 1'b1;
              end
            end
          end
        end
        default: d.st = q.st;
      endcase
    end

    d.busy = (d.er_left != '0) || (d.bcnt != '0);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      q      <= '0;
      q.st   <= S_IDLE;
      q.op   <= '{kind: K_NONE, has_addr: 1'b0, alanes: LANES_1, dlanes: LANES_1,
                  dmy: DMY_NONE};
      q.dcfg <= DMY_CFG_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_prog ? (mem[mem_wa] & mem_wd) : mem_wd;
    if (otp_we)
      otp[otp_wa] <= otp[otp_wa] & otp_wd;
    mem_rd_q <= mem[q.addr[AW-1:0]];
    otp_rd_q <= otp[q.addr[OTP_AW-1:0]];
  end
  assign pin_o                  = q.po;
  assign write_in_progress_flag = q.busy;

endmodule : qsf_flash // qsf_flash

// File: qsf_pkg.sv
// constants, opcodes and carrier types of the quad serial flash front end
package qsf_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned ARRAY_AW   = 23;
  localparam int unsigned PAGE_AW    = 8;
  localparam int unsigned OTP_AW     = 9;
  localparam int unsigned ADDR_BITS  = 24;
  localparam int unsigned SECTOR_AW  = 12;
  localparam int unsigned HALF_AW    = 15;
  localparam int unsigned BLOCK_AW   = 16;

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ   = 8'h03;
  localparam logic [7:0] OP_FAST   = 8'h0B;
  localparam logic [7:0] OP_DOUT   = 8'h3B;
  localparam logic [7:0] OP_DIO    = 8'hBB;
  localparam logic [7:0] OP_QIO    = 8'hEB;
  localparam logic [7:0] OP_PP     = 8'h02;
  localparam logic [7:0] OP_QPP    = 8'h32;
  localparam logic [7:0] OP_SE     = 8'h20;
  localparam logic [7:0] OP_HBE    = 8'h52;
  localparam logic [7:0] OP_BE     = 8'hD8;
  localparam logic [7:0] OP_CE     = 8'hC7;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_RDSR   = 8'h05;
  localparam logic [7:0] OP_SETDMY = 8'hC0;
  localparam logic [7:0] OP_OTPPR  = 8'h42;
  localparam logic [7:0] OP_OTPRD  = 8'h48;
  localparam logic [7:0] OP_OTPLK  = 8'h4A;

  // ----------------------------------------------------------------
  // status byte fields, dummy defaults, busy time
  // ----------------------------------------------------------------
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_WEL_BIT  = 1;
  localparam int unsigned ST_LOCK_BIT = 7;
  localparam logic [7:0]  DMY_CFG_RST = 8'h06;
  localparam logic [7:0]  DMY_BYTE_1L = 8'h08;
  localparam logic [7:0]  DMY_BYTE_2L = 8'h04;
  localparam int unsigned BUSY_CYC    = 64;

  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;

  typedef enum logic [1:0] {
    DMY_NONE = 2'h0, DMY_1L = 2'h1, DMY_2L = 2'h2, DMY_CFG = 2'h3
  } qsf_dmy_t;

  typedef enum logic [3:0] {
    K_NONE, K_WRITE_EN, K_WRDI, K_RDSR, K_READ, K_PROG, K_ERASE,
    K_SETDMY, K_OTPRD, K_OTPPR, K_OTPLK
  } qsf_kind_t;

  typedef enum logic [7:0] {
    S_IDLE   = 8'h01, S_CMD    = 8'h02, S_ADDR   = 8'h04, S_DUMMY  = 8'h08,
    S_DOUT   = 8'h10, S_DIN    = 8'h20, S_WAIT   = 8'h40, S_IGNORE = 8'h80
  } qsf_state_t;

  typedef struct packed {
    qsf_kind_t  kind;
    logic       has_addr;
    logic [2:0] alanes;
    logic [2:0] dlanes;
    qsf_dmy_t   dmy;
  } qsf_op_t;

  typedef struct packed {
    logic       sclk;
    logic       csb;
    logic [3:0] dq;
  } qsf_pins_in_t;

  typedef struct packed {
    logic [3:0] dq;
    logic [3:0] oe;
  } qsf_pins_out_t;

endpackage : qsf_pkg

// File: qsf_flash_asserts.sv
// port checker for the serial flash front end
`timescale 1ns/1ps
module qsf_flash_asserts #(
  parameter int unsigned BUSY_CYC = qsf_pkg::BUSY_CYC
) (
  input wire logic                   mclk,
  input wire logic                   resetn,
  input wire qsf_pkg::qsf_pins_in_t  pin_i,
  input wire qsf_pkg::qsf_pins_out_t pin_o,
  input wire logic                   write_in_progress_flag
);
  import qsf_pkg::*;
  // ------------------------------------
  // busy length and select history
  // ------------------------------------
  logic [31:0] busy_q;
  logic        seen_hi_q;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_q    <= 32'h0;
      seen_hi_q <= 1'b0;
    end
    else
    begin
      busy_q    <= write_in_progress_flag ? busy_q + 32'h1 : 32'h0;
      seen_hi_q <= seen_hi_q | pin_i.csb;
    end
  end
  // ------------------------------------
  // properties
  // ------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_desel;
    pin_i.csb [*3];
  endsequence
  sequence s_drive_on;
    $rose(|pin_o.oe);
  endsequence
  desel_release_a: assert property (s_desel |-> pin_o.oe == 4'h0)
    else $error("lanes driven while deselected");
  lanes_legal_a: assert property (pin_o.oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("illegal lane enable set");
  oe_steady_a: assert property ((|pin_o.oe) && (|$past(pin_o.oe)) |-> $stable(pin_o.oe))
    else $error("lane enables changed inside a frame");
  dout_fall_a: assert property
    ($changed(pin_o.dq) && (|pin_o.oe) && (|$past(pin_o.oe)) |-> !pin_i.sclk)
    else $error("read data changed while serial clock high");
  drive_on_a: assert property (s_drive_on |-> !pin_i.csb && !pin_i.sclk)
    else $error("lanes driven outside a selected low phase");
  quiet_ready_a: assert property (!seen_hi_q |-> pin_o.oe == 4'h0)
    else $error("answer before first select edge");
  busy_min_a: assert property ($fell(write_in_progress_flag) |-> busy_q >= BUSY_CYC)
    else $error("busy flag too short");
  busy_start_a: assert property ($rose(write_in_progress_flag) |-> pin_i.csb)
    else $error("busy flag rose while selected");
endmodule // qsf_flash_asserts
bind qsf_flash qsf_flash_asserts #(.BUSY_CYC(BUSY_CYC)) u_qsf_flash_asserts (
  .mclk(mclk), .resetn(resetn), .pin_i(pin_i), .pin_o(pin_o),
  .write_in_progress_flag(write_in_progress_flag));

// File: qsf_hm.sv
// behavioural spi host driving the flash pins
`timescale 1ns/1ps
module qsf_hm (
  input  wire logic                   mclk,
  output      qsf_pkg::qsf_pins_in_t  pin_i,
  input  wire qsf_pkg::qsf_pins_out_t pin_o
);
  import qsf_pkg::*;
  // ------------------------------------
  // pin levels and bus tasks
  // ------------------------------------
  logic       idle = 1'b0;
  logic       sclk = 1'b0;
  logic       csb  = 1'b0;
  logic [3:0] hv   = 4'h0;
  logic [3:0] hen  = 4'h0;
  logic [3:0] flt_q = 4'h5;
  always @(posedge mclk)
    flt_q <= ~flt_q;
  always_comb
  begin
    pin_i.sclk = sclk;
    pin_i.csb  = csb;
    for (int i = 0; i < 4; i++)
      pin_i.dq[i] = pin_o.oe[i] ? pin_o.dq[i] : (hen[i] ? hv[i] : flt_q[i]);
  end
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic sel();
    sclk = idle;
    wt(3);
    csb = 1'b0;
    wt(3);
  endtask
  task automatic desel();
    hen  = 4'h0;
    sclk = idle;
    wt(4);
    csb = 1'b1;
    wt(4);
  endtask
  task automatic io(input int ln, input logic wr, input logic [7:0] b, output logic [7:0] r);
    logic [7:0] sh;
    sh = b;
    r  = 8'h00;
    for (int c = 0; c < 8 / ln; c++)
    begin
      sclk = 1'b0;
      hen  = wr ? ((4'h1 << ln) - 4'h1) : 4'h0;
      hv   = ln == 4 ? sh[7:4] : (ln == 2 ? {2'h0, sh[7:6]} : {3'h0, sh[7]});
      wt(4);
      r  = ln == 4 ? {r[3:0], pin_i.dq} : (ln == 2 ? {r[5:0], pin_i.dq[1:0]} : {r[6:0], pin_i.dq[1]});
      sh = sh << ln;
      sclk = 1'b1;
      wt(4);
    end
  endtask
  task automatic tick(input int n);
    hen = 4'h0;
    repeat (n)
    begin
      sclk = 1'b0;
      wt(4);
      sclk = 1'b1;
      wt(4);
    end
  endtask
endmodule // qsf_hm

// File: quad_serial_flash_interface_tb.sv
// self-checking bench for the serial flash front end
`timescale 1ns/1ps
module quad_serial_flash_interface_tb;
  import qsf_pkg::*;
  // ------------------------------------
  // clock, reset, instances, helpers
  // ------------------------------------
  logic          mclk = 1'b0;
  logic          resetn = 1'b0;
  qsf_pins_in_t  pin_i;
  qsf_pins_out_t pin_o;
  logic          busy;
  int            bad_count = 0;
  int            cmp_count = 0;
  int            cyc = 0;
  logic [7:0]    r;
  qsf_flash #(.AW(16), .BUSY_CYC(400)) u_qsf_flash (
    .mclk(mclk), .resetn(resetn), .pin_i(pin_i), .pin_o(pin_o),
    .write_in_progress_flag(busy));
  qsf_hm u_qsf_hm (.mclk(mclk), .pin_i(pin_i), .pin_o(pin_o));
  always #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  task automatic op1(input logic [7:0] op);
    u_qsf_hm.sel();
    u_qsf_hm.io(1, 1'b1, op, r);
  endtask
  task automatic cmd(input logic [7:0] op);
    op1(op);
    u_qsf_hm.desel();
  endtask
  task automatic adr(input int ln, input logic [23:0] a);
    for (int i = 2; i >= 0; i--)
      u_qsf_hm.io(ln, 1'b1, a[8*i +: 8], r);
  endtask
  task automatic stat(input logic [7:0] exp);
    op1(OP_RDSR);
    u_qsf_hm.io(1, 1'b0, 8'h00, r);
    chk("status", r, exp);
    chk("status_oe", {4'h0, pin_o.oe}, 8'h02);
    u_qsf_hm.desel();
  endtask
  task automatic rd(input logic [7:0] op, input int al, input int dl, input int dm,
                    input logic [23:0] a, input logic [7:0] exp, input logic [3:0] eoe);
    op1(op);
    adr(al, a);
    u_qsf_hm.tick(dm);
    u_qsf_hm.io(dl, 1'b0, 8'h00, r);
    chk("read_data", r, exp);
    chk("read_oe", {4'h0, pin_o.oe}, {4'h0, eoe});
    u_qsf_hm.desel();
  endtask
  task automatic prog(input logic [7:0] op, input int ln, input logic [23:0] a,
                      input logic [23:0] d, input int n);
    op1(op);
    adr(1, a);
    for (int i = 0; i < n; i++)
      u_qsf_hm.io(ln, 1'b1, d[23 - 8*i -: 8], r);
    u_qsf_hm.desel();
  endtask
  task automatic settle();
    chk("busy_start", {7'h0, busy}, 8'h01);
    for (int i = 0; i < 9000 && busy === 1'b1; i++)
      @(negedge mclk);
    chk("busy_end", {7'h0, busy}, 8'h00);
  endtask
  // ------------------------------------
  // scenarios
  // ------------------------------------
  task automatic t_power();
    u_qsf_hm.io(1, 1'b1, OP_RDSR, r);
    u_qsf_hm.io(1, 1'b0, 8'h00, r);
    chk("pre_select_oe", {4'h0, pin_o.oe}, 8'h00);
    u_qsf_hm.desel();
    u_qsf_hm.tick(8);
    chk("deselect_oe", {4'h0, pin_o.oe}, 8'h00);
    $display("test power done");
  endtask
  task automatic t_status();
    stat(8'h00);
    cmd(OP_WRITE_EN);
    u_qsf_hm.idle = 1'b1;
    stat(8'h02);
    u_qsf_hm.idle = 1'b0;
    cmd(OP_WRDI);
    stat(8'h00);
    $display("test status done");
  endtask
  task automatic t_prog();
    cmd(OP_WRITE_EN);
    op1(OP_SE);
    adr(1, 24'h001000);
    u_qsf_hm.desel();
    settle();
    cmd(OP_WRITE_EN);
    prog(OP_PP, 1, 24'h0010FE, 24'hA53C0F, 3);
    cmd(OP_WRITE_EN);
    stat(8'h01);
    settle();
    cmd(OP_WRITE_EN);
    prog(OP_QPP, 4, 24'h0010FE, 24'hF00000, 1);
    settle();
    prog(OP_PP, 1, 24'h001100, 24'h000000, 1);
    chk("no_enable_busy", {7'h0, busy}, 8'h00);
    rd(OP_READ, 1, 1, 0, 24'h0010FE, 8'hA0, 4'h2);
    rd(OP_READ, 1, 1, 0, 24'h001000, 8'h0F, 4'h2);
    rd(OP_READ, 1, 1, 0, 24'h001100, 8'hFF, 4'h2);
    rd(OP_READ, 1, 1, 0, 24'h001FFF, 8'hFF, 4'h2);
    $display("test program done");
  endtask
  task automatic t_fast();
    rd(OP_FAST, 1, 1, 8, 24'h0010FE, 8'hA0, 4'h2);
    rd(OP_DOUT, 1, 2, 8, 24'h0010FF, 8'h3C, 4'h3);
    rd(OP_DIO, 2, 2, 4, 24'h001000, 8'h0F, 4'h3);
    rd(OP_QIO, 4, 4, 6, 24'h0010FE, 8'hA0, 4'hF);
    op1(OP_SETDMY);
    u_qsf_hm.io(1, 1'b1, 8'h02, r);
    u_qsf_hm.desel();
    rd(OP_QIO, 4, 4, 2, 24'h0010FF, 8'h3C, 4'hF);
    $display("test fast read done");
  endtask
  task automatic t_lock();
    cmd(OP_WRITE_EN);
    prog(OP_OTPPR, 1, 24'h000010, 24'h000000, 1);
    settle();
    rd(OP_OTPRD, 1, 1, 8, 24'h000010, 8'h00, 4'h2);
    cmd(OP_WRITE_EN);
    cmd(OP_OTPLK);
    settle();
    stat(8'h80);
    cmd(OP_WRITE_EN);
    prog(OP_OTPPR, 1, 24'h000011, 24'h000000, 1);
    chk("locked_busy", {7'h0, busy}, 8'h00);
    stat(8'h82);
    $display("test lock done");
  endtask
  initial
  begin
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    t_power();
    t_status();
    t_prog();
    t_fast();
    t_lock();
    give_verdict();
  end
endmodule // quad_serial_flash_interface_tb
